// ### hw/sci_regs.sv
/*
 Register bank of the card interface: serial two-wire slave, status,
 command and subregisters, interrupt, card clock divider and reset
 contact counter. Assumes the sequencer reports session, early and mute
 events on clk_i; card detect and bus pins are asynchronous.
*/
`timescale 1ns/1ns
module sci_regs
   import sci_pkg::*;
(
   input wire logic clk_i, // 20 MHz system clock
   input wire logic sys_rst_i, // Async reset, active high
   input wire logic scl_i, // Serial clock pin
   input wire logic sda_i, // Serial data pin level
   output logic sda_o, // Serial data drive value
   output logic sda_oe_o, // Serial data pull-low enable
   input wire logic address_strap_i, // Address bit 2 strap
   input wire logic card_inserted_i, // Debounced card detect pin
   input wire logic session_active_i, // Sequencer: card active
   input wire logic early_answer_i, // Sequencer: early answer pulse
   input wire logic no_answer_i, // Sequencer: mute pulse
   input wire logic overload_i, // Overload or overheat level
   input wire logic supervisor_fault_i, // Voltage supervisor active
   output sci_ctrl_s ctrl_o, // Controls to sequencer and pads
   output logic card_clk_o, // Card clock contact
   output logic card_rst_o, // Card reset contact
   output logic int_n_o // Interrupt, active low
);

   typedef struct packed {
      logic [2:0] sync_scl;
      logic [2:0] sync_sda;
      logic [2:0] sync_card_inserted_flag;
      logic scl_v;
      logic sda_v;
      logic card_inserted_flag_v;
      logic strap_done;
      logic strap;
      sci_bus_e st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic reg_sel;
      logic acked;
      logic rd_stat;
      logic oe;
      logic [7:0] cmd;
      logic [7:0] cfg;
      logic [7:0] early_cnt;
      logic [7:0] rc_hi;
      logic [7:0] rc_lo;
      logic early;
      logic mute;
      logic overload;
      logic supervisor_fault_flag;
      logic lowpower_clock_changed;
      logic insertion_change_flag;
      logic int_pend;
      logic int_n;
      logic async_m;
      logic [2:0] div_cnt;
      logic [3:0] osc_cnt;
      logic cclk;
      logic [15:0] rcnt;
      logic rst_hi;
      logic rst_out;
   } sci_state_s;

   sci_state_s s_q;
   sci_state_s s_d;

   // Read-cleared flag: a new event wins over the clear
   function automatic logic rc_flag(input logic cur, input logic set,
                                    input logic clr);
      rc_flag = set | (cur & ~clr);
   endfunction : rc_flag

   // Card clock half period in system cycles for a divider code
   function automatic logic [2:0] div_cycles(input logic [1:0] code);
      case (code)
         2'h0: div_cycles = 3'h1;
         2'h1: div_cycles = 3'h2;
         2'h2: div_cycles = 3'h4;
         default: div_cycles = 3'h5;
      endcase
   endfunction : div_cycles

   logic scl_n;
   logic sda_n;
   logic rise;
   logic fall;
   logic bus_start;
   logic bus_stop;
   logic rd_clr;
   logic wr_cmd;
   logic wr_sub;
   logic [7:0] status;
   logic [7:0] sub_rd;
   logic [7:0] tx;
   logic start_rise;
   logic warm_rise;
   logic [1:0] stop_sel;
   logic [1:0] div_code;
   logic [2:0] div_lim;
   logic cclk_rise;

   // Next state of the whole bank
   always_comb
   begin
      s_d = s_q;
      rd_clr = 1'b0;
      wr_cmd = 1'b0;
      wr_sub = 1'b0;
      // Pin synchronisers; a level counts once stages two and three agree
      s_d.sync_scl = {s_q.sync_scl[1:0], scl_i};
      s_d.sync_sda = {s_q.sync_sda[1:0], sda_i};
      s_d.sync_card_inserted_flag = {s_q.sync_card_inserted_flag[1:0], card_inserted_i};
      scl_n = (s_q.sync_scl[1] == s_q.sync_scl[2]) ?
              s_q.sync_scl[2] : s_q.scl_v;
      sda_n = (s_q.sync_sda[1] == s_q.sync_sda[2]) ?
              s_q.sync_sda[2] : s_q.sda_v;
      s_d.scl_v = scl_n;
      s_d.sda_v = sda_n;
      if (s_q.sync_card_inserted_flag[1] == s_q.sync_card_inserted_flag[2])
      begin
         s_d.card_inserted_flag_v = s_q.sync_card_inserted_flag[2];
      end
      // Strap caught once after reset release
      if (!s_q.strap_done)
      begin
         s_d.strap = address_strap_i;
         s_d.strap_done = 1'b1;
      end
      rise = scl_n & ~s_q.scl_v;
      fall = ~scl_n & s_q.scl_v;
      bus_start = s_q.scl_v & scl_n & s_q.sda_v & ~sda_n;
      bus_stop = s_q.scl_v & scl_n & ~s_q.sda_v & sda_n;

      // Status byte as seen by the host
      status = 8'h00;
      status[SCI_ST_ACTIVE] = session_active_i;
      status[SCI_ST_EARLY] = s_q.early;
      status[SCI_ST_MUTE] = s_q.mute;
      status[SCI_ST_OVERLOAD] = s_q.overload;
      status[SCI_ST_SUPERVISOR_FAULT_FLAG] = s_q.supervisor_fault_flag;
      status[SCI_ST_LOWPOWER_CLOCK_CHANGED] = s_q.lowpower_clock_changed;
      status[SCI_ST_INSERTION_CHANGE_FLAG] = s_q.insertion_change_flag;
      status[SCI_ST_CARD_INSERTED_FLAG] = s_q.card_inserted_flag_v;
      // Subregister picked by command bits 5:4
      case (s_q.cmd[SCI_CMD_SUBHI:SCI_CMD_SUBLO])
         SCI_SUB_CFG: sub_rd = s_q.cfg;
         SCI_SUB_EARLY: sub_rd = s_q.early_cnt;
         SCI_SUB_RCHI: sub_rd = s_q.rc_hi;
         default: sub_rd = s_q.rc_lo;
      endcase
      tx = s_q.reg_sel ? sub_rd : status;

      // Serial slave; drive changes only after a falling clock edge
      case (s_q.st)
         SCI_IDLE:
         begin
            s_d.oe = 1'b0;
         end
         SCI_ADDR, SCI_WBYTE:
         begin
            if (rise)
            begin
               s_d.sh = {s_q.sh[6:0], sda_n};
               s_d.cnt = s_q.cnt + 4'h1;
            end
            if (fall && s_q.cnt == 4'h8)
            begin
               s_d.cnt = 4'h0;
               if (s_q.st == SCI_WBYTE)
               begin
                  wr_cmd = ~s_q.reg_sel;
                  wr_sub = s_q.reg_sel;
                  s_d.oe = 1'b1;
                  s_d.st = SCI_WACK;
               end
               else if (s_q.sh[7:3] == SCI_ADDR_HI &&
                        s_q.sh[2] == s_q.strap)
               begin
                  s_d.reg_sel = s_q.sh[1];
                  s_d.rw = s_q.sh[0];
                  s_d.oe = 1'b1;
                  s_d.st = SCI_AACK;
               end
               else
               begin
                  s_d.st = SCI_IDLE;
               end
            end
         end
         SCI_AACK:
         begin
            if (fall)
            begin
               if (s_q.rw)
               begin
                  s_d.sh = tx;
                  s_d.oe = ~tx[7];
                  s_d.cnt = 4'h1;
                  s_d.rd_stat = ~s_q.reg_sel;
                  s_d.st = SCI_RBYTE;
               end
               else
               begin
                  s_d.oe = 1'b0;
                  s_d.st = SCI_WBYTE;
               end
            end
         end
         SCI_WACK:
         begin
            if (fall)
            begin
               s_d.oe = 1'b0;
               s_d.st = SCI_WBYTE;
            end
         end
         SCI_RBYTE:
         begin
            if (fall)
            begin
               if (s_q.cnt == 4'h8)
               begin
                  s_d.oe = 1'b0;
                  s_d.acked = 1'b0;
                  s_d.st = SCI_RACK;
               end
               else
               begin
                  s_d.sh = {s_q.sh[6:0], 1'b1};
                  s_d.oe = ~s_q.sh[6];
                  s_d.cnt = s_q.cnt + 4'h1;
               end
            end
         end
         SCI_RACK:
         begin
            // Flags clear once the whole status byte has gone out
            if (rise)
            begin
               rd_clr = s_q.rd_stat;
               s_d.acked = ~sda_n;
               if (sda_n)
               begin
                  s_d.st = SCI_IDLE;
               end
            end
            if (fall && s_q.acked)
            begin
               s_d.sh = tx;
               s_d.oe = ~tx[7];
               s_d.cnt = 4'h1;
               s_d.st = SCI_RBYTE;
            end
         end
         default:
         begin
            s_d.st = SCI_IDLE;
            s_d.oe = 1'b0;
         end
      endcase
      if (bus_start)
      begin
         s_d.st = SCI_ADDR;
         s_d.cnt = 4'h0;
         s_d.oe = 1'b0;
      end
      else if (bus_stop)
      begin
         s_d.st = SCI_IDLE;
         s_d.oe = 1'b0;
      end

      // Command write; supply and stop bits frozen during a session
      if (wr_cmd)
      begin
         s_d.cmd[SCI_CMD_IOEN] = s_q.sh[SCI_CMD_IOEN];
         s_d.cmd[SCI_CMD_SUBHI] = s_q.sh[SCI_CMD_SUBHI];
         s_d.cmd[SCI_CMD_SUBLO] = s_q.sh[SCI_CMD_SUBLO];
         s_d.cmd[SCI_CMD_WARM] = s_q.sh[SCI_CMD_WARM];
         if (!s_q.cmd[SCI_CMD_START])
         begin
            s_d.cmd[SCI_CMD_LOWSUP] = s_q.sh[SCI_CMD_LOWSUP];
            s_d.cmd[SCI_CMD_HISUP] = s_q.sh[SCI_CMD_HISUP];
            s_d.cmd[SCI_CMD_STOP] = s_q.sh[SCI_CMD_STOP];
         end
         s_d.cmd[SCI_CMD_START] = s_q.sh[SCI_CMD_START] &
            (s_q.cmd[SCI_CMD_START] | (~s_q.supervisor_fault_flag & s_q.card_inserted_flag_v));
      end
      else if (no_answer_i)
      begin
         s_d.cmd[SCI_CMD_WARM] = 1'b0;
      end
      // Subregister write through the selector
      if (wr_sub)
      begin
         case (s_q.cmd[SCI_CMD_SUBHI:SCI_CMD_SUBLO])
            SCI_SUB_CFG: s_d.cfg = s_q.sh;
            SCI_SUB_EARLY: s_d.early_cnt = s_q.sh;
            SCI_SUB_RCHI: s_d.rc_hi = s_q.sh;
            default: s_d.rc_lo = s_q.sh;
         endcase
      end
      start_rise = s_d.cmd[SCI_CMD_START] & ~s_q.cmd[SCI_CMD_START];
      warm_rise = s_d.cmd[SCI_CMD_WARM] & ~s_q.cmd[SCI_CMD_WARM];

      // Status flags; answer flags rearm with each activation
      s_d.early = early_answer_i | (s_q.early & ~start_rise);
      s_d.mute = no_answer_i | (s_q.mute & ~start_rise);
      s_d.overload = rc_flag(s_q.overload,
         overload_i & session_active_i, rd_clr);
      s_d.supervisor_fault_flag = rc_flag(s_q.supervisor_fault_flag, supervisor_fault_i, rd_clr);
      s_d.lowpower_clock_changed = (wr_sub && s_q.cmd[SCI_CMD_STOP] &&
         s_q.cmd[SCI_CMD_SUBHI:SCI_CMD_SUBLO] == SCI_SUB_CFG &&
         s_q.sh[SCI_CF_STOPHI:SCI_CF_STOPLO] !=
         s_q.cfg[SCI_CF_STOPHI:SCI_CF_STOPLO]) |
         (s_q.lowpower_clock_changed & ~start_rise);
      s_d.insertion_change_flag = rc_flag(s_q.insertion_change_flag,
         s_d.card_inserted_flag_v ^ s_q.card_inserted_flag_v, rd_clr);
      // Pending interrupt survives until a status read completes
      s_d.int_pend = rc_flag(s_q.int_pend,
         (s_d.card_inserted_flag_v ^ s_q.card_inserted_flag_v) | (overload_i & session_active_i) |
         no_answer_i | early_answer_i, rd_clr);
      s_d.int_n = ~(s_d.int_pend | supervisor_fault_i);

      // Management mode fixed at activation by the reset level bit
      if (start_rise)
      begin
         s_d.async_m = s_q.cfg[SCI_CF_RSTLVL];
      end
      stop_sel = s_q.async_m ? s_q.cfg[SCI_CF_STOPHI:SCI_CF_STOPLO] :
                 {1'b0, s_q.cfg[SCI_CF_STOPLO]};
      div_code = s_q.async_m ? s_q.cfg[1:0] : 2'h0;
      div_lim = div_cycles(div_code);

      // Card clock; base is the system clock, so divide 1 is clk/2
      if (!session_active_i)
      begin
         s_d.cclk = 1'b0;
         s_d.div_cnt = 3'h0;
      end
      else if (s_q.cmd[SCI_CMD_STOP])
      begin
         case (stop_sel)
            2'h0: s_d.cclk = 1'b0;
            2'h1: s_d.cclk = 1'b1;
            2'h2:
            begin
               if (s_q.osc_cnt >= SCI_OSC_HALF - 4'h1)
               begin
                  s_d.osc_cnt = 4'h0;
                  s_d.cclk = ~s_q.cclk;
               end
               else
               begin
                  s_d.osc_cnt = s_q.osc_cnt + 4'h1;
               end
            end
            default: s_d.cclk = s_q.cclk;
         endcase
      end
      else if (s_q.div_cnt + 3'h1 >= div_lim)
      begin
         s_d.div_cnt = 3'h0;
         s_d.cclk = ~s_q.cclk;
      end
      else
      begin
         s_d.div_cnt = s_q.div_cnt + 3'h1;
      end
      cclk_rise = s_d.cclk & ~s_q.cclk;

      // Reset contact: async mode holds it low for the programmed card clock count, sync mode drives the reset level bit
      if (start_rise || warm_rise)
      begin
         s_d.rcnt = 16'h0000;
         s_d.rst_hi = 1'b0;
      end
      else if (s_q.rcnt >= {s_q.rc_hi, s_q.rc_lo})
      begin
         s_d.rst_hi = 1'b1;
      end
      else if (cclk_rise)
      begin
         s_d.rcnt = s_q.rcnt + 16'h0001;
      end
      if (!session_active_i)
      begin
         s_d.rst_out = 1'b0;
      end
      else
      begin
         s_d.rst_out = s_q.async_m ? s_q.rst_hi :
                       s_q.cfg[SCI_CF_RSTLVL];
      end
   end

   // State register; supervisor flag and interrupt set from power-on
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         s_q <= '0;
         s_q.sync_scl <= 3'h7;
         s_q.sync_sda <= 3'h7;
         s_q.scl_v <= 1'b1;
         s_q.sda_v <= 1'b1;
         s_q.st <= SCI_IDLE;
         s_q.cmd <= SCI_CMD_RST;
         s_q.cfg <= SCI_CFG_RST;
         s_q.early_cnt <= SCI_EARLY_RST;
         s_q.rc_hi <= SCI_RCHI_RST;
         s_q.rc_lo <= SCI_RCLO_RST;
         s_q.supervisor_fault_flag <= 1'b1;
         s_q.int_n <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs, all from state flip-flops except sda_o, which is a constant 0
   assign sda_o = 1'b0; // Open drain: only ever pulls low
   assign sda_oe_o = s_q.oe;
   assign card_clk_o = s_q.cclk;
   assign card_rst_o = s_q.rst_out;
   assign int_n_o = s_q.int_n;
   assign ctrl_o.low_supply_select = s_q.cmd[SCI_CMD_LOWSUP];
   assign ctrl_o.supply_high_select = s_q.cmd[SCI_CMD_HISUP];
   assign ctrl_o.io_passthrough_on = s_q.cmd[SCI_CMD_IOEN];
   assign ctrl_o.clock_stop_mode = s_q.cmd[SCI_CMD_STOP];
   assign ctrl_o.warm_reset = s_q.cmd[SCI_CMD_WARM];
   assign ctrl_o.activate = s_q.cmd[SCI_CMD_START];
   assign ctrl_o.test_mode = s_q.cfg[SCI_CF_TEST];
   assign ctrl_o.aux_contact_eight_level = s_q.cfg[SCI_CF_AUX8];
   assign ctrl_o.aux_contact_four_level = s_q.cfg[SCI_CF_AUX4];
   assign ctrl_o.async_mode = s_q.async_m;
   assign ctrl_o.early_window_count = s_q.early_cnt;
   assign ctrl_o.reset_count = {s_q.rc_hi, s_q.rc_lo};
endmodule : sci_regs

// ### hw/sci_pkg.sv
/*
 Constants, register layouts and carrier types for the card interface
 register bank. Assumes a 20 MHz system clock that also serves as the
 master clock from which the card clock is divided.
*/
// Functional notes
// - Register 0 reads status, takes command; command bits 5:4 pick subregister.
// - Status bit 7 shows an active card session.
// - Status bit 6 sets when the card answers too early.
// - Status bit 5 sets when the card stays mute during answer slots.
// - Status bit 4 sets on overload or overheat; clears after status read.
// - Status bit 3 sets on supervisor fault; clears after status read.
// - Status bit 2 sets when clock changes during power-down mode.
// - Status bit 1 sets on insertion or extraction; clears after status read.
// - Status bit 0 shows card presence.
// - Interrupt low while change, overload, mute or early flag pending.
// - Supervisor flag set from power-on; interrupt low while supervisor active.
// - Command bit 7 picks 1.8 V, else bit 2 picks 5/3 V; locked in session.
// - Command bit 6 passes the host I/O line to the card I/O.
// - Command bit 3 selects stop clock and low power; locked in session.
// - Command bit 1 starts warm reset; hardware clears it on mute.
// - Command bit 0 activates only without supervisor fault and with a card.
// - Subregister 00 bit 7 selects test mode.
// - Subregister 00 bit 6 drives reset contact; at start picks async mode.
// - Subregister 00 bits 5 and 4 drive the two auxiliary contacts.
// - Subregister 00 bits 3:2 pick clock stop state; sync mode forces bit 3.
// - Subregister 00 bits 1:0 divide card clock by 1,2,4,5; sync forces 00.
// - Subregister 01 holds early window count, initial value 170.
// - Slave address bit 1 picks register, bit 0 picks read or write.
// - Async mode holds reset low for the 16-bit count of card clocks.
package sci_pkg;
   // Serial slave address, upper five bits fixed
   localparam logic [4:0] SCI_ADDR_HI = 5'h08;
   // Status bit positions
   localparam int SCI_ST_ACTIVE = 7;
   localparam int SCI_ST_EARLY = 6;
   localparam int SCI_ST_MUTE = 5;
   localparam int SCI_ST_OVERLOAD = 4;
   localparam int SCI_ST_SUPERVISOR_FAULT_FLAG = 3;
   localparam int SCI_ST_LOWPOWER_CLOCK_CHANGED = 2;
   localparam int SCI_ST_INSERTION_CHANGE_FLAG = 1;
   localparam int SCI_ST_CARD_INSERTED_FLAG = 0;
   // Command bit positions
   localparam int SCI_CMD_LOWSUP = 7;
   localparam int SCI_CMD_IOEN = 6;
   localparam int SCI_CMD_SUBHI = 5;
   localparam int SCI_CMD_SUBLO = 4;
   localparam int SCI_CMD_STOP = 3;
   localparam int SCI_CMD_HISUP = 2;
   localparam int SCI_CMD_WARM = 1;
   localparam int SCI_CMD_START = 0;
   // Subregister 00 bit positions
   localparam int SCI_CF_TEST = 7;
   localparam int SCI_CF_RSTLVL = 6;
   localparam int SCI_CF_AUX8 = 5;
   localparam int SCI_CF_AUX4 = 4;
   localparam int SCI_CF_STOPHI = 3;
   localparam int SCI_CF_STOPLO = 2;
   // Subregister selectors
   localparam logic [1:0] SCI_SUB_CFG = 2'h0;
   localparam logic [1:0] SCI_SUB_EARLY = 2'h1;
   localparam logic [1:0] SCI_SUB_RCHI = 2'h2;
   localparam logic [1:0] SCI_SUB_RCLO = 2'h3;
   // Reset values
   localparam logic [7:0] SCI_CMD_RST = 8'h00;
   localparam logic [7:0] SCI_CFG_RST = 8'h00;
   localparam logic [7:0] SCI_EARLY_RST = 8'hAA;
   localparam logic [7:0] SCI_RCHI_RST = 8'hA4;
   localparam logic [7:0] SCI_RCLO_RST = 8'h74;
   // Internal oscillator stand-in for the stop/osc-by-two clock choice
   localparam int SCI_OSC_HZ = 2_000_000;
   localparam int SCI_CLK_HZ = 20_000_000;
   localparam logic [3:0] SCI_OSC_HALF =
      4'((SCI_CLK_HZ / SCI_OSC_HZ) / 2);

   typedef enum logic [2:0] {
      SCI_IDLE, SCI_ADDR, SCI_AACK, SCI_WBYTE, SCI_WACK, SCI_RBYTE, SCI_RACK
   } sci_bus_e;

   // Controls handed to the contact sequencer and pads
   typedef struct packed {
      logic low_supply_select;
      logic supply_high_select;
      logic io_passthrough_on;
      logic clock_stop_mode;
      logic warm_reset;
      logic activate;
      logic test_mode;
      logic aux_contact_eight_level;
      logic aux_contact_four_level;
      logic async_mode;
      logic [7:0] early_window_count;
      logic [15:0] reset_count;
   } sci_ctrl_s;
endpackage : sci_pkg

// ### verif/sci_regs_monitor.sv
/*
 Port checker for the card interface register bank.
 Assumes one clock domain and the bench's pull-up on the data line.
*/
`timescale 1ns/1ns
module sci_regs_monitor
   import sci_pkg::*;
(
   input wire logic clk_i, // System clock
   input wire logic sys_rst_i, // Async reset
   input wire logic scl_i, // Serial clock
   input wire logic sda_i, // Data level
   input wire logic sda_o, // Data value
   input wire logic sda_oe_o, // Data pull enable
   input wire logic address_strap_i, // Address strap
   input wire logic card_inserted_i, // Card detect
   input wire logic session_active_i, // Session level
   input wire logic early_answer_i, // Early pulse
   input wire logic no_answer_i, // Mute pulse
   input wire logic overload_i, // Overload level
   input wire logic supervisor_fault_i, // Supervisor level
   input wire sci_ctrl_s ctrl_o, // Controls
   input wire logic card_clk_o, // Card clock
   input wire logic card_rst_o, // Card reset
   input wire logic int_n_o // Interrupt
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Event steps
   sequence s_event;
      early_answer_i || no_answer_i;
   endsequence
   sequence s_mute_warm;
      no_answer_i && ctrl_o.warm_reset;
   endsequence
   sequence s_held;
      ctrl_o.activate && $past(ctrl_o.activate);
   endsequence
   property p_event_int;
      s_event |-> ##[1:3] !int_n_o;
   endproperty
   a_event_int: assert property (p_event_int)
      else $error("interrupt not raised after event");
   property p_sup_int;
      supervisor_fault_i |=> !int_n_o;
   endproperty
   a_sup_int: assert property (p_sup_int)
      else $error("interrupt high during supervisor fault");
   property p_lowsup_lock;
      s_held |-> $stable(ctrl_o.low_supply_select);
   endproperty
   a_lowsup_lock: assert property (p_lowsup_lock)
      else $error("low supply changed in session");
   property p_hisup_lock;
      s_held |-> $stable(ctrl_o.supply_high_select);
   endproperty
   a_hisup_lock: assert property (p_hisup_lock)
      else $error("high supply changed in session");
   property p_stop_lock;
      s_held |-> $stable(ctrl_o.clock_stop_mode);
   endproperty
   a_stop_lock: assert property (p_stop_lock)
      else $error("stop mode changed in session");
   property p_warm_clr;
      s_mute_warm |-> ##[1:2] !ctrl_o.warm_reset;
   endproperty
   a_warm_clr: assert property (p_warm_clr)
      else $error("warm bit kept after mute");
   property p_rst_idle;
      !session_active_i [*2] |-> !card_rst_o;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("reset contact high while inactive");
   property p_sda_change;
      $changed(sda_oe_o) |-> !scl_i;
   endproperty
   a_sda_change: assert property (p_sda_change)
      else $error("data line changed while clock high");
endmodule : sci_regs_monitor

bind sci_regs sci_regs_monitor u_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .address_strap_i(address_strap_i), .card_inserted_i(card_inserted_i),
   .session_active_i(session_active_i), .early_answer_i(early_answer_i),
   .no_answer_i(no_answer_i), .overload_i(overload_i),
   .supervisor_fault_i(supervisor_fault_i), .ctrl_o(ctrl_o),
   .card_clk_o(card_clk_o), .card_rst_o(card_rst_o), .int_n_o(int_n_o));

// ### verif/sci_host.sv
/*
 Host model: two-wire bus master doing one-byte transfers.
 Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ns
module sci_host
(
   input wire logic clk_i, // System clock
   input wire logic sda_i, // Resolved data line
   output logic scl_o, // Serial clock
   output logic sda_pull_o // Pulls data low
);
   localparam int Q = 10; // Quarter bit, slow enough for the filter
   initial
   begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   task automatic wq(input int n);
      repeat (n * Q) @(posedge clk_i);
   endtask : wq
   // Data moves only while the clock is low
   task automatic bit_io(input logic b, output logic s);
      sda_pull_o <= !b;
      wq(1);
      scl_o <= 1'b1;
      wq(2);
      s = sda_i;
      scl_o <= 1'b0;
      wq(1);
   endtask : bit_io
   // Ack slot always released: write ack is read, read ends in nack
   task automatic byte_io(input logic [7:0] d, output logic [7:0] r,
      output logic k);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], s);
         r[i] = s;
      end
      bit_io(1'b1, s);
      k = !s;
   endtask : byte_io
   // Address bit 1 picks register, bit 0 read
   task automatic xfer(input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] r, output logic k);
      logic [7:0] x;
      logic kd;
      sda_pull_o <= 1'b1;
      wq(2);
      scl_o <= 1'b0;
      wq(1);
      byte_io(a, x, k);
      if (k)
      begin
         byte_io(a[0] ? 8'hFF : d, r, kd);
         k = a[0] | kd;
      end
      sda_pull_o <= 1'b1;
      wq(1);
      scl_o <= 1'b1;
      wq(2);
      sda_pull_o <= 1'b0;
      wq(2);
   endtask : xfer
endmodule : sci_host

// ### verif/testbench.sv
/*
 Self-checking bench for the card interface register bank.
 Assumes the host model and the bound port checker.
*/
`timescale 1ns/1ns
module testbench;
   import sci_pkg::*;
   typedef struct packed {
      logic [1:0] sub;
      logic [7:0] rst;
      logic [7:0] wr;
   } sci_row_s;
   logic clk_i, sys_rst_i, scl, pull, sda_oe, card, sess, early, mute;
   logic ovl, sup, card_clk, card_rst, int_n;
   logic [7:0] r;
   wire sda;
   sci_ctrl_s ctrl;
   sci_row_s rows [4];
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   // Open-drain line with pull-up
   assign sda = !(pull | sda_oe);
   sci_host u_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
      .sda_pull_o(pull));
   sci_regs u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl),
      .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .address_strap_i(1'b0),
      .card_inserted_i(card), .session_active_i(sess),
      .early_answer_i(early), .no_answer_i(mute), .overload_i(ovl),
      .supervisor_fault_i(sup), .ctrl_o(ctrl), .card_clk_o(card_clk),
      .card_rst_o(card_rst), .int_n_o(int_n));
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = !clk_i;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
         mismatches++;
      end
   endtask : chk
   task automatic acc(input logic [7:0] a, input logic [7:0] d,
      input logic ek, output logic [7:0] q);
      logic k;
      u_host.xfer(a, d, q, k);
      chk("ack", {7'h0, ek}, {7'h0, k});
   endtask : acc
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   task automatic pulse(input logic e);
      @(posedge clk_i);
      early <= e;
      mute <= !e;
      @(posedge clk_i);
      early <= 1'b0;
      mute <= 1'b0;
   endtask : pulse
   // Hang guard, far above the expected run
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         mismatches++;
         give_verdict();
      end
   end
   initial
   begin
      {sys_rst_i, sup} = 2'b11;
      {card, sess, early, mute, ovl} = 5'h00;
      rows = '{'{SCI_SUB_CFG, SCI_CFG_RST, 8'hB0},
         '{SCI_SUB_EARLY, 8'hAA, 8'h00}, '{SCI_SUB_RCHI, SCI_RCHI_RST, 8'hFF},
         '{SCI_SUB_RCLO, SCI_RCLO_RST, 8'h01}};
      tick(2);
      sys_rst_i <= 1'b0;
      tick(6);
      chk("int", 8'h00, {7'h0, int_n});
      acc(8'h41, 8'h00, 1'b1, r);
      chk("status", 8'h08, r);
      sup <= 1'b0;
      acc(8'h41, 8'h00, 1'b1, r);
      chk("status", 8'h08, r);
      chk("int", 8'h01, {7'h0, int_n});
      acc(8'h40, 8'h01, 1'b1, r);
      chk("act", 8'h00, {7'h0, ctrl.activate});
      card <= 1'b1;
      tick(10);
      chk("int", 8'h00, {7'h0, int_n});
      acc(8'h41, 8'h00, 1'b1, r);
      chk("status", 8'h03, r);
      chk("int", 8'h01, {7'h0, int_n});
      acc(8'h41, 8'h00, 1'b1, r);
      chk("status", 8'h01, r);
      for (int i = 0; i < 4; i++)
      begin
         acc(8'h40, {2'h0, rows[i].sub, 4'h0}, 1'b1, r);
         acc(8'h43, 8'h00, 1'b1, r);
         chk("sub reset", rows[i].rst, r);
         acc(8'h42, rows[i].wr, 1'b1, r);
         acc(8'h43, 8'h00, 1'b1, r);
         chk("sub data", rows[i].wr, r);
      end
      chk("window", 8'h00, ctrl.early_window_count);
      chk("cnt hi", 8'hFF, ctrl.reset_count[15:8]);
      chk("cnt lo", 8'h01, ctrl.reset_count[7:0]);
      chk("cfg", 8'h07, {5'h0, ctrl.test_mode,
         ctrl.aux_contact_eight_level, ctrl.aux_contact_four_level});
      acc(8'h45, 8'h00, 1'b0, r);
      // Activation, then locked supply bits
      acc(8'h40, 8'hC1, 1'b1, r);
      chk("ctl", 8'h0F, {4'h0, ctrl.activate, ctrl.io_passthrough_on,
         ctrl.low_supply_select, 1'b1});
      sess <= 1'b1;
      acc(8'h40, 8'h05, 1'b1, r);
      chk("lock", 8'h02, {6'h0, ctrl.low_supply_select,
         ctrl.supply_high_select});
      // Sync mode, no stop: card clock flips on every system clock
      @(negedge clk_i);
      r[0] = card_clk;
      @(negedge clk_i);
      chk("card clk", {7'h0, !r[0]}, {7'h0, card_clk});
      pulse(1'b1);
      tick(4);
      chk("int", 8'h00, {7'h0, int_n});
      acc(8'h41, 8'h00, 1'b1, r);
      chk("status", 8'hC1, r);
      acc(8'h40, 8'h83, 1'b1, r);
      chk("warm", 8'h01, {7'h0, ctrl.warm_reset});
      pulse(1'b0);
      tick(4);
      chk("warm", 8'h00, {7'h0, ctrl.warm_reset});
      acc(8'h41, 8'h00, 1'b1, r);
      chk("status", 8'hE1, r);
      ovl <= 1'b1;
      tick(10);
      ovl <= 1'b0;
      acc(8'h41, 8'h00, 1'b1, r);
      chk("status", 8'hF1, r);
      acc(8'h41, 8'h00, 1'b1, r);
      chk("status", 8'hE1, r);
      acc(8'h40, 8'h00, 1'b1, r);
      sess <= 1'b0;
      chk("act", 8'h00, {7'h0, ctrl.activate});
      // Stop state changed while idle raises the clock-change flag
      acc(8'h40, 8'h08, 1'b1, r);
      acc(8'h42, 8'hBC, 1'b1, r);
      acc(8'h41, 8'h00, 1'b1, r);
      chk("status", 8'h65, r);
      tick(4);
      give_verdict();
   end
endmodule : testbench
